// file: ufi_core.sv
`timescale 1ns/1ps
// ----------------------------------------
// shared constants and types
// ----------------------------------------
package ufi_pkg;
  localparam int SYS_HZ = 20000000;
  localparam int REF_HZ = 1843200;
  localparam logic [17:0] REF_STEP = 18'(REF_HZ / 100);
  localparam logic [17:0] REF_WRAP = 18'(SYS_HZ / 100);
  localparam logic [15:0] DIV_RST = 16'h000C;
  localparam logic DL_ADDR_LO = 1'b0;
  localparam logic DL_ADDR_HI = 1'b1;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0E;
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_RXDATA = 4'h4;
  localparam logic [3:0] IIR_TIMEOUT = 4'hC;
  localparam logic [3:0] IIR_TXEMPTY = 4'h2;
  localparam logic [3:0] BITS_START = 4'h1;
  localparam logic [3:0] BITS_WORD_MIN = 4'h5;
  localparam logic [7:0] TIMEOUT_CHARS = 8'h04;
  typedef struct packed {
    logic fifo_mode_enable;
    logic rx_data_int_enable;
    logic tx_int_enable;
    logic [1:0] rx_trigger_level_sel;
    logic [1:0] word_len_sel;
    logic parity_en;
    logic two_stop;
    logic host_irq_output_gate;
    logic divisor_latch_access;
  } ufi_cfg_t;
endpackage : ufi_pkg

// What this block does
// - divisor sets bit rate from 1.8432 MHz
// - rx interrupts need fifo mode and enable
// - data-ready flag tracks nonempty rx fifo
// - code 4h while count at trigger
// - irq follows any posted identity code
// - code Ch after four idle characters
// - second stop bit counts in char time
// - code 2h from tx empty until cleared
// - tx write or identity read clears 2h
// - delay empty unless two bytes seen
// - first tx interrupt after enable immediate
// - divisor bytes at 0 and 1 with access
// - irq driven only while output gate set
module ufi_core (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire ufi_pkg::ufi_cfg_t i_cfg,
  input wire logic i_dl_wr,
  input wire logic i_dl_rd,
  input wire logic i_dl_addr,
  input wire logic [7:0] i_dl_wdata,
  output logic [7:0] o_dl_rdata,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  output logic o_rx_ready,
  input wire logic i_host_rx_rd,
  output logic [7:0] o_host_rx_data,
  input wire logic i_host_tx_wr,
  input wire logic [7:0] i_host_tx_data,
  input wire logic i_host_iir_rd,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  output logic o_bit_tick,
  output logic o_rx_ready_flag,
  output logic o_tx_holding_empty,
  output logic [4:0] o_rx_count,
  output logic [3:0] o_int_identity_reg,
  output logic o_host_irq_out,
  output logic o_host_irq_oe_n
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // second stop bit counted
  function automatic logic [3:0] char_bits(input ufi_pkg::ufi_cfg_t c);
    char_bits = ufi_pkg::BITS_START + ufi_pkg::BITS_WORD_MIN + {2'b00, c.word_len_sel}
      + {3'b000, c.parity_en} + 4'h1 + {3'b000, c.two_stop};
  endfunction : char_bits

  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'b00: trig_level = ufi_pkg::TRIG_L0;
      2'b01: trig_level = ufi_pkg::TRIG_L1;
      2'b10: trig_level = ufi_pkg::TRIG_L2;
      2'b11: trig_level = ufi_pkg::TRIG_L3;
    endcase
  endfunction : trig_level

  // timeout span in bit times, four characters
  function automatic logic [7:0] timeout_bits(input logic [3:0] cb);
    timeout_bits = ufi_pkg::TIMEOUT_CHARS * {4'h0, cb};
  endfunction : timeout_bits

  default clocking cb_sys @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  // ----------------------------------------
  // divisor latch and bit rate
  // ----------------------------------------
  logic [15:0] div_ff;
  logic [17:0] ref_acc_ff;
  logic [19:0] pre_cnt_ff;
  logic [7:0] dl_rdata_ff;
  wire [17:0] ref_sum = ref_acc_ff + ufi_pkg::REF_STEP;
  wire ref_tick = ref_sum >= ufi_pkg::REF_WRAP;
  wire [17:0] nxt_ref_acc = ref_tick ? ref_sum - ufi_pkg::REF_WRAP : ref_sum;
  // divisor 0 behaves as 1 rather than stalling the bit clock
  wire [19:0] pre_top = {(div_ff == 16'h0000) ? 16'h0001 : div_ff, 4'h0} - 20'h00001;
  wire bit_tick = ref_tick && (pre_cnt_ff >= pre_top);
  wire dl_wr_lo = i_dl_wr && i_cfg.divisor_latch_access && (i_dl_addr == ufi_pkg::DL_ADDR_LO);
  wire dl_wr_hi = i_dl_wr && i_cfg.divisor_latch_access && (i_dl_addr == ufi_pkg::DL_ADDR_HI);
  wire [7:0] dl_sel = (i_dl_addr == ufi_pkg::DL_ADDR_HI) ? div_ff[15:8] : div_ff[7:0];

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      div_ff <= ufi_pkg::DIV_RST;
      dl_rdata_ff <= 8'h00;
    end else begin
      if (dl_wr_lo) div_ff[7:0] <= i_dl_wdata;
      if (dl_wr_hi) div_ff[15:8] <= i_dl_wdata;
      if (i_dl_rd && i_cfg.divisor_latch_access) dl_rdata_ff <= dl_sel;
    end
  end

  // sixteen reference ticks per divisor count
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ref_acc_ff <= 18'h00000;
      pre_cnt_ff <= 20'h00000;
    end else begin
      ref_acc_ff <= nxt_ref_acc;
      if (bit_tick) pre_cnt_ff <= 20'h00000;
      else if (ref_tick) pre_cnt_ff <= pre_cnt_ff + 20'h00001;
    end
  end

  // ----------------------------------------
  // two-entry receive buffer and rx fifo
  // ----------------------------------------
  logic [7:0] sk0_ff, sk1_ff;
  logic [1:0] sk_cnt_ff;
  logic [7:0] rx_mem [16];
  logic [3:0] rx_wp_ff, rx_rp_ff;
  logic [4:0] rx_cnt_ff;
  logic [7:0] rx_rdata_ff;
  wire sk_in = i_rx_valid && o_rx_ready;
  wire rx_push = (sk_cnt_ff != 2'b00) && (rx_cnt_ff != ufi_pkg::FIFO_DEPTH);
  wire rx_pop = i_host_rx_rd && (rx_cnt_ff != 5'h00);
  wire sk_to_head = (sk_cnt_ff == 2'b00) || ((sk_cnt_ff == 2'b01) && rx_push);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sk0_ff <= 8'h00;
      sk1_ff <= 8'h00;
      sk_cnt_ff <= 2'b00;
    end else begin
      if (rx_push) sk0_ff <= sk1_ff;
      if (sk_in && sk_to_head) sk0_ff <= i_rx_data;
      if (sk_in && !sk_to_head) sk1_ff <= i_rx_data;
      sk_cnt_ff <= sk_cnt_ff + {1'b0, sk_in} - {1'b0, rx_push};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rx_push) rx_mem[rx_wp_ff] <= sk0_ff;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rx_wp_ff <= 4'h0;
      rx_rp_ff <= 4'h0;
      rx_cnt_ff <= 5'h00;
      rx_rdata_ff <= 8'h00;
    end else begin
      if (rx_push) rx_wp_ff <= rx_wp_ff + 4'h1;
      if (rx_pop) rx_rp_ff <= rx_rp_ff + 4'h1;
      if (rx_pop) rx_rdata_ff <= rx_mem[rx_rp_ff];
      rx_cnt_ff <= rx_cnt_ff + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end

  // ----------------------------------------
  // receive timeout
  // ----------------------------------------
  logic [7:0] to_cnt_ff;
  wire [3:0] cb_now = char_bits(i_cfg);
  wire [7:0] to_limit = timeout_bits(cb_now);
  wire rx_int_on = i_cfg.fifo_mode_enable && i_cfg.rx_data_int_enable;
  // idle after arrival and host read
  wire rx_timeout = rx_int_on && (rx_cnt_ff != 5'h00) && (to_cnt_ff > to_limit);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) to_cnt_ff <= 8'h00;
    else if (rx_push || rx_pop) to_cnt_ff <= 8'h00;
    else if (bit_tick && (to_cnt_ff != 8'hFF)) to_cnt_ff <= to_cnt_ff + 8'h01;
  end

  // ----------------------------------------
  // tx fifo and empty interrupt
  // ----------------------------------------
  logic [7:0] tx_mem [16];
  logic [3:0] tx_wp_ff, tx_rp_ff;
  logic [4:0] tx_cnt_ff;
  logic empty_prev_ff, fe_prev_ff, two_seen_ff, first_ff, dly_act_ff, tx_pend_ff;
  logic [3:0] dly_cnt_ff;
  wire tx_push = i_host_tx_wr && (tx_cnt_ff != ufi_pkg::FIFO_DEPTH);
  wire tx_pop = o_tx_valid && i_tx_ready;
  wire tx_empty = tx_cnt_ff == 5'h00;
  wire fe_rise = i_cfg.fifo_mode_enable && !fe_prev_ff;
  wire empty_rise = tx_empty && !empty_prev_ff;
  wire tx_int_on = i_cfg.fifo_mode_enable && i_cfg.tx_int_enable;
  wire imm_set = tx_int_on && ((fe_rise && tx_empty) || (empty_rise && (two_seen_ff || first_ff)));
  // delayed empty, one char minus stop
  wire dly_start = tx_int_on && empty_rise && !two_seen_ff && !first_ff && !fe_rise;
  wire dly_done = dly_act_ff && bit_tick && (dly_cnt_ff <= 4'h1);
  wire tx_set = imm_set || (dly_done && tx_int_on);
  wire tx_clr = i_host_tx_wr || (i_host_iir_rd && (o_int_identity_reg == ufi_pkg::IIR_TXEMPTY));
  // pending while enabled, set beats clear
  wire nxt_tx_pend = tx_set || (tx_pend_ff && !tx_clr && tx_int_on);

  always_ff @(posedge i_clk_sys) begin
    if (tx_push) tx_mem[tx_wp_ff] <= i_host_tx_data;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tx_wp_ff <= 4'h0;
      tx_rp_ff <= 4'h0;
      tx_cnt_ff <= 5'h00;
    end else begin
      if (tx_push) tx_wp_ff <= tx_wp_ff + 4'h1;
      if (tx_pop) tx_rp_ff <= tx_rp_ff + 4'h1;
      tx_cnt_ff <= tx_cnt_ff + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      empty_prev_ff <= 1'b1;
      fe_prev_ff <= 1'b0;
      two_seen_ff <= 1'b0;
      first_ff <= 1'b0;
      dly_act_ff <= 1'b0;
      dly_cnt_ff <= 4'h0;
      tx_pend_ff <= 1'b0;
    end else begin
      empty_prev_ff <= tx_empty;
      fe_prev_ff <= i_cfg.fifo_mode_enable;
      if (empty_rise) two_seen_ff <= 1'b0;
      else if (tx_cnt_ff >= 5'h02) two_seen_ff <= 1'b1;
      // an immediate set at the enable edge uses up the first interrupt
      if (tx_set) first_ff <= 1'b0;
      else if (fe_rise) first_ff <= 1'b1;
      if (dly_start) begin
        dly_act_ff <= 1'b1;
        dly_cnt_ff <= cb_now - 4'h1;
      end else if (dly_done || i_host_tx_wr || !tx_int_on) begin
        dly_act_ff <= 1'b0;
      end else if (dly_act_ff && bit_tick) begin
        dly_cnt_ff <= dly_cnt_ff - 4'h1;
      end
      tx_pend_ff <= nxt_tx_pend;
    end
  end

  // ----------------------------------------
  // identity code and host irq
  // ----------------------------------------
  // trigger level reached
  // rx codes gated by mode and enable
  wire rx_trig = rx_int_on && (rx_cnt_ff >= trig_level(i_cfg.rx_trigger_level_sel));
  wire [3:0] iir_code = rx_trig ? ufi_pkg::IIR_RXDATA :
                        rx_timeout ? ufi_pkg::IIR_TIMEOUT :
                        tx_pend_ff ? ufi_pkg::IIR_TXEMPTY : ufi_pkg::IIR_NONE;

  assign o_int_identity_reg = iir_code;
  // irq whenever a code is posted and the output gate is set
  assign o_host_irq_out = i_cfg.host_irq_output_gate && (iir_code != ufi_pkg::IIR_NONE);
  assign o_host_irq_oe_n = !i_cfg.host_irq_output_gate;
  assign o_rx_ready_flag = rx_cnt_ff != 5'h00;
  assign o_tx_holding_empty = tx_empty;
  assign o_rx_ready = sk_cnt_ff != 2'b10;
  assign o_rx_count = rx_cnt_ff;
  assign o_host_rx_data = rx_rdata_ff;
  assign o_tx_valid = !tx_empty;
  assign o_tx_data = tx_mem[tx_rp_ff];
  assign o_dl_rdata = dl_rdata_ff;
  assign o_bit_tick = bit_tick;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_div_lo_load: assert property (dl_wr_lo |=> div_ff[7:0] == $past(i_dl_wdata))
    else $error("divisor low byte not loaded");
  a_bit_spacing: assert property (bit_tick |=> !bit_tick [*8])
    else $error("bit ticks too close");
  a_rx_flag: assert property ((rx_cnt_ff == 5'h00) |-> !o_rx_ready_flag)
    else $error("data-ready set with empty fifo");
  a_rx_flag_set: assert property ((rx_push && !rx_pop) |=> o_rx_ready_flag)
    else $error("data-ready missing after push");
  a_rx_gate: assert property (!rx_int_on |-> iir_code != ufi_pkg::IIR_RXDATA && iir_code != ufi_pkg::IIR_TIMEOUT)
    else $error("rx code while disabled");
  a_trig_code: assert property (rx_trig |-> iir_code == ufi_pkg::IIR_RXDATA && o_host_irq_out == i_cfg.host_irq_output_gate)
    else $error("trigger level code or irq missing");
  a_irq_tristate: assert property (!i_cfg.host_irq_output_gate |-> o_host_irq_oe_n && !o_host_irq_out)
    else $error("irq driven while gated");
  a_timeout_wait: assert property ((to_cnt_ff <= to_limit) |-> iir_code != ufi_pkg::IIR_TIMEOUT)
    else $error("timeout code too early");
  a_stop_len: assert property (i_cfg.two_stop |-> cb_now >= 4'h8)
    else $error("second stop bit missing from char time");
  a_first_imm: assert property ((tx_int_on && fe_rise && tx_empty) |=> tx_pend_ff)
    else $error("first tx interrupt delayed");
  a_tx_wr_clear: assert property ((i_host_tx_wr && !tx_set && tx_pend_ff) |=> !tx_pend_ff)
    else $error("tx code not cleared by write");
  a_dly_hold: assert property ((dly_act_ff && !tx_set && !tx_pend_ff && !i_host_tx_wr) |=> !tx_pend_ff)
    else $error("delayed empty raised early");
  a_tx_code: assert property ((tx_pend_ff && !rx_trig && !rx_timeout) |-> iir_code == ufi_pkg::IIR_TXEMPTY)
    else $error("tx code not posted");
endmodule : ufi_core

// file: ufi_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// far-side byte sink for the tx stream
// ----------------------------------------
module ufi_far_model (
  input wire logic i_clk_sys,
  input wire logic i_hold,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  output logic o_ready
);
  logic [7:0] got_q[$];
  int seed = 32'h00005A3C;
  initial o_ready = 1'b0;
  // takes bytes in order, only while o_ready is set
  // random stalls: a slow line must lose nothing
  always @(posedge i_clk_sys) begin
    if (i_valid && o_ready) got_q.push_back(i_data);
    #2 o_ready = !i_hold && (($random(seed) & 1) != 0);
  end
endmodule : ufi_far_model

// file: test_uart_fifo_interrupt_logic.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench
// ----------------------------------------
module test_uart_fifo_interrupt_logic;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ufi_pkg::ufi_cfg_t cfg = '0;
  logic dl_wr = 1'b0, dl_rd = 1'b0, dl_addr = 1'b0, rx_valid = 1'b0, rx_rd = 1'b0;
  logic tx_wr = 1'b0, iir_rd = 1'b0, hold = 1'b0;
  logic [7:0] dl_wdata = 8'h00, rx_data = 8'h00, tx_data = 8'h00;
  logic [7:0] dl_rdata, host_rx_data, tx_byte;
  logic rx_ready, tx_valid, tx_ready, tick, rdy_flag, hold_empty, irq, irq_oe_n;
  logic [4:0] rx_count;
  logic [3:0] code;
  int err_total = 0, samples_checked = 0, seed = 32'hF7DFE60C, k, lvl, cb;
  logic [7:0] exp_q[$], tx_exp[$];
  always #25 clk = ~clk;
  ufi_core ufi_core_inst (.i_clk_sys(clk), .i_sys_rst(rst), .i_cfg(cfg), .i_dl_wr(dl_wr), .i_dl_rd(dl_rd),
    .i_dl_addr(dl_addr), .i_dl_wdata(dl_wdata), .o_dl_rdata(dl_rdata), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .o_rx_ready(rx_ready), .i_host_rx_rd(rx_rd), .o_host_rx_data(host_rx_data),
    .i_host_tx_wr(tx_wr), .i_host_tx_data(tx_data), .i_host_iir_rd(iir_rd), .o_tx_valid(tx_valid),
    .o_tx_data(tx_byte), .i_tx_ready(tx_ready), .o_bit_tick(tick), .o_rx_ready_flag(rdy_flag),
    .o_tx_holding_empty(hold_empty), .o_rx_count(rx_count), .o_int_identity_reg(code),
    .o_host_irq_out(irq), .o_host_irq_oe_n(irq_oe_n));
  ufi_far_model ufi_far_model_inst (.i_clk_sys(clk), .i_hold(hold), .i_valid(tx_valid), .i_data(tx_byte),
    .o_ready(tx_ready));
  task automatic step(int n = 1);
    repeat (n) begin @(posedge clk); #2; end
  endtask : step
  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic fail(string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail
  task automatic chk_bit(logic g, logic e, string m);
    samples_checked++;
    if (g !== e) fail(m);
  endtask : chk_bit
  task automatic chk_byte(logic [7:0] g, logic [7:0] e, string m);
    samples_checked++;
    if (g !== e) fail(m);
  endtask : chk_byte
  task automatic chk_code(logic [3:0] e, string m);
    samples_checked++;
    if (code !== e) fail(m);
  endtask : chk_code
  // a tick is a one-cycle pulse, so it is looked at every cycle
  task automatic wait_ticks(int n);
    int c = 0;
    while (c < n) begin if (tick === 1'b1) c++; step(); end
  endtask : wait_ticks
  task automatic push_n(int n);
    logic r;
    int g;
    rx_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      rx_data = 8'($random(seed));
      exp_q.push_back(rx_data);
      g = 0;
      do begin r = rx_ready; step(); g++; end while (r !== 1'b1 && g < 50);
      if (g >= 50) fail("rx push stalled");
    end
    rx_valid = 1'b0;
  endtask : push_n
  task automatic pop_n(int n);
    rx_rd = 1'b1;
    repeat (n) begin
      step();
      chk_byte(host_rx_data, exp_q.pop_front(), "rx data order");
    end
    rx_rd = 1'b0;
    step(2);
  endtask : pop_n
  task automatic dl(logic w, logic a, logic [7:0] d);
    dl_wr = w; dl_rd = !w; dl_addr = a; dl_wdata = d;
    step();
    dl_wr = 1'b0; dl_rd = 1'b0;
    step();
  endtask : dl
  // tb-side occupancy only holds while the sink is held
  task automatic txw(int n);
    tx_wr = 1'b1;
    repeat (n) begin
      tx_data = 8'($random(seed));
      if (tx_exp.size() - ufi_far_model_inst.got_q.size() < 16) tx_exp.push_back(tx_data);
      step();
    end
    tx_wr = 1'b0;
    step();
  endtask : txw
  task automatic wait_empty();
    int g = 0;
    while (hold_empty !== 1'b1 && g < 4000) begin step(); g++; end
    if (g >= 4000) fail("tx never drained");
  endtask : wait_empty
  function automatic int bit_cycles(int d);
    return 20000000 * 10 * d / 115200;
  endfunction : bit_cycles
  initial begin
    #3000000;
    fail("watchdog");
    conclude();
  end
  initial begin
    cfg.fifo_mode_enable = 1'b1; cfg.rx_data_int_enable = 1'b1; cfg.word_len_sel = 2'h3;
    cfg.host_irq_output_gate = 1'b1; cfg.divisor_latch_access = 1'b1;
    step(4);
    rst = 1'b0;
    chk_code(4'h1, "reset code");
    chk_bit(hold_empty, 1'b1, "reset tx empty");
    dl(1'b0, 1'b0, 8'h00); chk_byte(dl_rdata, 8'h0C, "divisor lo reset");
    dl(1'b0, 1'b1, 8'h00); chk_byte(dl_rdata, 8'h00, "divisor hi reset");
    dl(1'b1, 1'b1, 8'h00);
    for (int d = 1; d < 3; d++) begin
      dl(1'b1, 1'b0, 8'(d));
      k = 0;
      repeat (bit_cycles(d)) begin if (tick === 1'b1) k++; step(); end
      chk_bit(k >= 9 && k <= 11, 1'b1, "bit rate");
    end
    dl(1'b1, 1'b0, 8'h01);
    cfg.divisor_latch_access = 1'b0;
    dl(1'b1, 1'b0, 8'h55);
    cfg.divisor_latch_access = 1'b1;
    dl(1'b0, 1'b0, 8'h00); chk_byte(dl_rdata, 8'h01, "divisor write gated");
    for (int s = 0; s < 4; s++) begin
      lvl = (s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 8 : 14;
      cfg.rx_trigger_level_sel = 2'(s);
      if (lvl > 1) push_n(lvl - 1);
      step(3);
      chk_code(4'h1, "code below level");
      chk_bit(rdy_flag, lvl > 1, "data-ready flag");
      push_n(1);
      step(3);
      chk_byte({3'h0, rx_count}, 8'(lvl), "rx count");
      chk_code(4'h4, "code at level");
      chk_bit(irq, 1'b1, "irq at level");
      chk_bit(irq_oe_n, 1'b0, "irq driven");
      cfg.host_irq_output_gate = 1'b0;
      step();
      chk_bit(irq_oe_n, 1'b1, "irq released");
      chk_bit(irq, 1'b0, "irq low while released");
      cfg.host_irq_output_gate = 1'b1; cfg.rx_data_int_enable = 1'b0;
      step();
      chk_code(4'h1, "rx int disabled");
      cfg.rx_data_int_enable = 1'b1;
      pop_n(1);
      chk_code(4'h1, "code dropped");
      chk_bit(irq, 1'b0, "irq dropped");
      if (lvl > 1) pop_n(lvl - 1);
      chk_bit(rdy_flag, 1'b0, "flag clear when empty");
    end
    push_n(18);
    step(3);
    chk_bit(rx_ready, 1'b0, "rx buffer refuses");
    chk_byte({3'h0, rx_count}, 8'h10, "rx fifo full");
    pop_n(18);
    for (int t = 0; t < 2; t++) begin
      cfg.two_stop = t[0]; cfg.parity_en = t[0]; cfg.word_len_sel = t[0] ? 2'h2 : 2'h3;
      cb = 10 + t;
      push_n(1);
      wait_ticks(4 * cb - 2);
      chk_code(4'h1, "timeout early");
      wait_ticks(4);
      chk_code(4'hC, "timeout code");
      pop_n(1);
    end
    cfg.two_stop = 1'b0; cfg.parity_en = 1'b0; cfg.word_len_sel = 2'h3; cfg.fifo_mode_enable = 1'b0;
    cfg.tx_int_enable = 1'b1;
    step(2);
    cfg.fifo_mode_enable = 1'b1;
    step(2);
    chk_code(4'h2, "first tx int immediate");
    iir_rd = 1'b1;
    step();
    iir_rd = 1'b0;
    step();
    chk_code(4'h1, "identity read clears");
    txw(1);
    wait_empty();
    wait_ticks(7);
    chk_code(4'h1, "single byte delays");
    wait_ticks(4);
    chk_code(4'h2, "delayed tx empty");
    hold = 1'b1;
    txw(17);
    chk_code(4'h1, "tx write clears");
    hold = 1'b0;
    wait_empty();
    step(2);
    chk_code(4'h2, "two bytes no delay");
    chk_byte(8'(ufi_far_model_inst.got_q.size()), 8'(tx_exp.size()), "tx byte count");
    foreach (tx_exp[i]) chk_byte(ufi_far_model_inst.got_q[i], tx_exp[i], "tx data order");
    conclude();
  end
endmodule : test_uart_fifo_interrupt_logic
